// [adc_sample_output_pipeline.sv]
// Digital model of an 8-bit sampling converter with a six-cycle output pipeline
//
// Summary of operation
// - Input between references becomes 8-bit code
// - Input below bottom reference gives all zeros
// - Input above top reference gives all ones
// - Sample each edge; code appears six cycles later
// - One new code per cycle while running
// - Power-down input high suspends conversion
// - Powered down: output holds last code
// - Clock stopped: output keeps last code
`timescale 1ns/100ps
`include "adc_pipe_map.svh"
module adc_sample_output_pipeline #(
  parameter int          AW            = `ANALOG_WIDTH,
  parameter int          LATENCY       = `PIPE_LATENCY,
  parameter int unsigned SETTLE_CYCLES = `SETTLE_CYCLES
) (
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic [AW-1:0]             analog_level_i,
  input  wire logic [AW-1:0]             top_reference_level_i,
  input  wire logic [AW-1:0]             bottom_reference_level_i,
  input  wire logic                      low_power_select_i,
  output adc_pipe_pkg::conv_word_t       word_o,
  output logic                           word_valid_o,
  input  wire logic                      capture_ready_i,
  output logic                           accurate_o
);

  localparam int WW = $bits(adc_pipe_pkg::conv_word_t);
  localparam int CW = $clog2(SETTLE_CYCLES + 1);

  // *************************************
  // Power-down pin synchroniser
  // *************************************
  logic lp_meta_q;
  logic lp_sync_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lp_meta_q <= 1'b0;
      lp_sync_q <= 1'b0;
    end else begin
      lp_meta_q <= low_power_select_i;
      lp_sync_q <= lp_meta_q;
    end
  end

  // *************************************
  // Quantiser
  // *************************************
  function automatic adc_pipe_pkg::conv_word_t quantise(
    input logic [AW-1:0] lvl,
    input logic [AW-1:0] top,
    input logic [AW-1:0] bot
  );
    adc_pipe_pkg::conv_word_t w;
    logic [AW+7:0]            num;
    logic [AW+7:0]            span;
    logic [AW+7:0]            q;
    w           = '0;
    num         = '0;
    span        = '0;
    q           = '0;
    if (lvl < bot) begin
      w.below_range = 1'b1;
      w.code        = `CODE_ALL_ZERO;
    end else if (lvl > top) begin
      w.above_range = 1'b1;
      w.code        = `CODE_ALL_ONE;
    end else if (top == bot) begin
      w.code = `CODE_ALL_ZERO;
    end else begin
      num    = (AW+8)'(lvl - bot) * (AW+8)'(`CODE_ALL_ONE);
      span   = (AW+8)'(top - bot);
      q      = num / span;
      w.code = q[7:0];
    end
    return w;
  endfunction

  adc_pipe_pkg::conv_word_t quant_c;
  assign quant_c = quantise(analog_level_i, top_reference_level_i, bottom_reference_level_i);

  // *************************************
  // Pipeline stages
  // *************************************
  logic                     buf_in_ready;
  logic                     advance;
  logic                     stage_v_q [LATENCY];
  adc_pipe_pkg::conv_word_t stage_q   [LATENCY];

  // Stall on power-down or on a full buffer; a stalled stage keeps its word
  assign advance = !lp_sync_q && buf_in_ready;

  generate
    for (genvar s = 0; s < LATENCY; s++) begin : g_stage
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          stage_v_q[s] <= 1'b0;
        end else if (advance) begin
          stage_v_q[s] <= (s == 0) ? 1'b1 : stage_v_q[(s == 0) ? 0 : s-1];
        end
      end
      always_ff @(posedge clk_i) begin
        if (advance) begin
          stage_q[s] <= (s == 0) ? quant_c : stage_q[(s == 0) ? 0 : s-1];
        end
      end
    end
  endgenerate

  // *************************************
  // Output buffer
  // *************************************
  logic [WW-1:0] buf_out;

  // Output register holds its word while frozen or unclocked
  two_entry_buffer #(
    .W (WW)
  ) u_buf (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (stage_v_q[LATENCY-1] && !lp_sync_q),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (stage_q[LATENCY-1]),
    .out_valid_o (word_valid_o),
    // Frozen while powered down, so a parked skid word cannot surface; capture ignores words then
    .out_ready_i (capture_ready_i && !lp_sync_q),
    .out_data_o  (buf_out)
  );

  assign word_o = adc_pipe_pkg::conv_word_t'(buf_out);

  // *************************************
  // Accuracy settle after wake
  // *************************************
  logic [CW-1:0] settle_q;

  // Marks the window in which the capture side should discard codes
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      settle_q <= '0;
    end else if (lp_sync_q) begin
      settle_q <= CW'(SETTLE_CYCLES);
    end else if (settle_q != '0) begin
      settle_q <= settle_q - CW'(1);
    end
  end

  assign accurate_o = (settle_q == '0) && !lp_sync_q;

  // *************************************
  // Assertions
  // *************************************
  // Word lands six edges after its sample, so it is first sampled at the seventh
  sequence s_running7;
    (advance && capture_ready_i)[*7];
  endsequence

  a_code_latency: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_running7 |=> word_o == $past(quant_c, 7))
    else $error("code did not appear six cycles after its sample");

  a_clamp_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    quant_c.below_range |-> quant_c.code == `CODE_ALL_ZERO && !quant_c.above_range)
    else $error("input below bottom reference not all zeros");

  a_clamp_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (analog_level_i > top_reference_level_i) |-> quant_c.code == `CODE_ALL_ONE)
    else $error("input above top reference not all ones");

  a_code_range: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (analog_level_i == top_reference_level_i && top_reference_level_i > bottom_reference_level_i)
      |-> quant_c.code == `CODE_ALL_ONE && !quant_c.above_range)
    else $error("full-scale input did not give the top code");

  a_sleep_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lp_sync_q && $past(lp_sync_q) |-> $stable(word_o))
    else $error("output bus changed while powered down");

  a_sleep_stall: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lp_sync_q |=> $stable(stage_q[0]) && $stable(stage_v_q[LATENCY-1]))
    else $error("pipeline moved while powered down");

  a_one_per_cycle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (advance && capture_ready_i)[*8] |=> word_valid_o)
    else $error("steady conversion did not yield a code every cycle");

  a_out_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    word_valid_o && !capture_ready_i |=> $stable(word_o) && word_valid_o)
    else $error("unaccepted output word changed");

  a_settle_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(lp_sync_q) |-> !accurate_o ##1 !accurate_o)
    else $error("accuracy flag rose too soon after wake");

endmodule

// [adc_pipe_map.svh]
// Constants of the sampling converter output pipeline
`ifndef ADC_PIPE_MAP_SVH
`define ADC_PIPE_MAP_SVH

// *************************************
// Code format
// *************************************
`define CODE_WIDTH        8
`define CODE_ALL_ZERO     8'h00
`define CODE_ALL_ONE      8'hff
`define ANALOG_WIDTH      12

// *************************************
// Timing
// *************************************
`define PIPE_LATENCY      6
`define CLK_FREQ_MHZ      200
`define SETTLE_TIME_US    1000
`define SETTLE_CYCLES     (`SETTLE_TIME_US * `CLK_FREQ_MHZ)

`endif

// [adc_pipe_pkg.sv]
// Types shared by the converter output pipeline
package adc_pipe_pkg;

  // *************************************
  // Converted word with range flags
  // *************************************
  typedef struct packed {
    logic       below_range;
    logic       above_range;
    logic [7:0] code;
  } conv_word_t;

endpackage

// [two_entry_buffer.sv]
// Two-entry buffer with registered output and a skid slot
`timescale 1ns/100ps
module two_entry_buffer #(
  parameter int W = 10
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  logic         out_v_q;
  logic         skid_v_q;
  logic [W-1:0] out_q;
  logic [W-1:0] skid_q;

  // Ready never looks at in_valid, so no combinational loop upstream
  assign in_ready_o  = !skid_v_q;
  assign out_valid_o = out_v_q;
  assign out_data_o  = out_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      out_v_q  <= 1'b0;
      skid_v_q <= 1'b0;
    end else if (!out_v_q || out_ready_i) begin
      if (skid_v_q) begin
        out_v_q  <= 1'b1;
        skid_v_q <= 1'b0;
      end else begin
        out_v_q  <= in_valid_i;
      end
    end else if (in_valid_i && !skid_v_q) begin
      skid_v_q <= 1'b1;
    end
  end

  // Data holds whenever nothing new is taken
  always_ff @(posedge clk_i) begin
    if (!out_v_q || out_ready_i) begin
      if (skid_v_q) begin
        out_q <= skid_q;
      end else if (in_valid_i) begin
        out_q <= in_data_i;
      end
    end else if (in_valid_i && !skid_v_q) begin
      skid_q <= in_data_i;
    end
  end

endmodule

// [capture_model.sv]
// Capture logic that latches converter words on the sample clock
`timescale 1ns/100ps
module capture_model (
  input  wire logic                     clk_i,
  input  wire logic                     sys_rst_i,
  input  wire adc_pipe_pkg::conv_word_t word_i,
  input  wire logic                     valid_i,
  input  wire logic                     accurate_i,
  input  wire logic                     stall_i,
  output logic                          ready_o,
  output adc_pipe_pkg::conv_word_t      got_o,
  output logic [7:0]                    got_count_o
);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ready_o     <= 1'b0;
      got_count_o <= 8'h00;
    end else begin
      ready_o <= !stall_i;
      // Words seen while settling are dropped, not counted
      if (valid_i && ready_o && accurate_i) begin
        got_o       <= word_i;
        got_count_o <= got_count_o + 8'h01;
      end
    end
  end
endmodule

// [adc_sample_output_pipeline_tb.sv]
// Self-checking bench for the converter output pipeline
`timescale 1ns/100ps
module adc_sample_output_pipeline_tb;
  logic                     clk_i = 1'b0;
  logic                     clk_run = 1'b1;
  logic                     sys_rst_i = 1'b1;
  logic                     low_power = 1'b0;
  logic                     stall = 1'b0;
  logic [11:0]              lvl = 12'h000;
  logic [11:0]              top = 12'h900;
  logic [11:0]              bot = 12'h100;
  adc_pipe_pkg::conv_word_t word;
  adc_pipe_pkg::conv_word_t got;
  adc_pipe_pkg::conv_word_t held;
  logic                     valid;
  logic                     ready;
  logic                     accurate;
  logic [7:0]               got_count;
  logic [7:0]               cnt0;
  int                       err_total = 0;
  int                       cmp_count = 0;
  int                       n;
  // Level beside expected {below, above, code}
  logic [21:0] rows [10] = '{
    {12'h000, 10'h200}, {12'h0ff, 10'h200}, {12'h100, 10'h000}, {12'h101, 10'h000},
    {12'h500, 10'h07f}, {12'h8ff, 10'h0fe}, {12'h900, 10'h0ff}, {12'h901, 10'h1ff},
    {12'hfff, 10'h1ff}, {12'h300, 10'h03f}};

  // 200 MHz at 50% duty, the rate at which the converter is specified
  always #2.5 clk_i = clk_run ? ~clk_i : clk_i;

  adc_sample_output_pipeline #(.SETTLE_CYCLES(20)) i_adc_sample_output_pipeline (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .analog_level_i(lvl), .top_reference_level_i(top),
    .bottom_reference_level_i(bot), .low_power_select_i(low_power), .word_o(word),
    .word_valid_o(valid), .capture_ready_i(ready), .accurate_o(accurate));

  capture_model i_capture_model (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .word_i(word), .valid_i(valid), .accurate_i(accurate),
    .stall_i(stall), .ready_o(ready), .got_o(got), .got_count_o(got_count));

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  // *************************************
  // Main sequence
  // *************************************
  initial begin
    tick(4);
    check(valid, 1'b0);
    check(accurate, 1'b1);
    sys_rst_i = 1'b0;
    begin : scenarios
      // One new level per cycle; each word must land exactly seven ticks later
      for (int k = 0; k < 17; k++) begin
        if (k < 10) lvl = rows[k][21:10];
        if (k >= 7) begin
          check(word, rows[k-7][9:0]);
          check(valid, 1'b1);
        end else if (k == 6) begin
          check(valid, 1'b0);
        end
        tick(1);
      end
      repeat (8) begin
        lvl = lvl + 12'h080;
        tick(1);
      end
      stall = 1'b1;
      tick(2);
      held = word;
      cnt0 = got_count;
      repeat (4) begin
        tick(1);
        check(word, held);
        check(valid, 1'b1);
      end
      stall = 1'b0;
      n = 0;
      while (got_count == cnt0 && n < 8) begin
        tick(1);
        n++;
      end
      if (n == 8) begin
        err_total++;
        disable scenarios;
      end
      check(got, held);
      tick(8);
      held = word;
      clk_run = 1'b0;
      lvl = 12'h000;
      #40;
      check(word, held);
      // Clock resumes; the new level goes on just after the first edge
      clk_run = 1'b1;
      tick(1);
      lvl = 12'h500;
      tick(7);
      low_power = 1'b1;
      lvl = 12'hfff;
      tick(3);
      check(accurate, 1'b0);
      check(word, 10'h07f);
      tick(20);
      check(word, 10'h07f);
      low_power = 1'b0;
      cnt0 = got_count;
      n = 0;
      while (accurate !== 1'b1 && n < 40) begin
        tick(1);
        n++;
      end
      check(n >= 20 && n <= 24, 1'b1);
      check(word, 10'h1ff);
      check(got_count, cnt0);
      tick(1);
      check(got_count, 8'(cnt0 + 8'h01));
      check(got, 10'h1ff);
    end
    print_verdict();
  end
endmodule
